// ### verilog/olm_pkg.sv
// constants, types and register map of the optical link mode/status block
// assumes one 200 MHz clock and an asynchronous active-low reset
`default_nettype none

package olm_pkg;
    // timing
    localparam longint CLK_HZ    = 200_000_000;
    localparam longint HOLD_MS   = 2000;
    localparam longint HOLD_CYC  = (HOLD_MS * CLK_HZ) / 1000;
    localparam longint DEB_MS    = 10;
    localparam longint DEB_CYC   = (DEB_MS * CLK_HZ) / 1000;
    localparam longint BLINK_MS  = 250;
    localparam longint BLINK_CYC = (BLINK_MS * CLK_HZ) / 1000;

    // modes, top-to-bottom order of the indicator column
    localparam int         NUM_MODES  = 6;
    localparam logic [2:0] M_NORMAL   = 3'h0;
    localparam logic [2:0] M_HAND     = 3'h1;
    localparam logic [2:0] M_ALIGN    = 3'h2;
    localparam logic [2:0] M_POINTER  = 3'h3;
    localparam logic [2:0] M_DROPOUT  = 3'h4;
    localparam logic [2:0] M_UPSTREAM = 3'h5;

    // register map, byte addresses
    localparam int         AXI_AW    = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQS = 8'h08;
    localparam logic [7:0] ADDR_IRQM = 8'h0c;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_LVL  = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVE = 2'h2;

    // fields
    localparam int CTRL_TXOFF = 0;
    localparam int IRQ_W      = 4;
    localparam int IRQ_WARN   = 0;
    localparam int IRQ_STOP   = 1;
    localparam int IRQ_LINK   = 2;
    localparam int IRQ_MODE   = 3;
    localparam int MODE_PEND  = 8;
    localparam int MODE_SEL   = 12;

    // reset values
    localparam logic             CTRL_RST = 1'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 4'h0;

    typedef struct packed {
        logic upstream;
        logic dropout;
        logic pointer;
        logic align;
        logic hand;
        logic normal;
    } olm_modes_t;

    localparam olm_modes_t MODES_RST = 6'h01;

    typedef struct packed {
        logic green_any;
        logic orange_any;
    } olm_lvl_t;
endpackage

`default_nettype wire

// ### verilog/olm_top.sv
// mode selection, level warning and transmit gating of an optical link station
// assumes all inputs but RESET_N and MODE_BTN synchronous to CLK; RX_LEVEL is the modem's level sample
`default_nettype none

module olm_top
    import olm_pkg::*;
#(
    parameter int     LVL_W       = 8,
    parameter int     N_ORANGE    = 2,
    parameter int     N_GREEN     = 4,
    parameter int     SEG_STEP    = 40,
    parameter longint HOLD_CYCLES = HOLD_CYC,
    parameter longint DEB_CYCLES  = DEB_CYC,
    parameter longint BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic                      CLK,
    input  wire logic                      RESET_N,
    input  wire logic [LVL_W-1:0]          RX_LEVEL,
    input  wire logic                      OPT_LINK_OK,
    input  wire logic                      EMIT_DIS_IN,
    input  wire logic                      MODE_BTN,
    output logic                           LEVEL_WARN_N,
    output logic                           TX_ENABLE,
    output logic                           DATA_PASS,
    output logic                           OPT_LINK_LED,
    output olm_modes_t                     MODE_LED,
    output logic [N_ORANGE+N_GREEN-1:0]    BARGRAPH,
    output logic                           ETH_SPEED_100,
    output logic                           ETH_FULL_DUPLEX,
    output logic                           ETH_AUTO_MDIX,
    output logic                           IRQ,
    input  wire logic [AXI_AW-1:0]         S_AXI_AWADDR,
    input  wire logic                      S_AXI_AWVALID,
    output logic                           S_AXI_AWREADY,
    input  wire logic [31:0]               S_AXI_WDATA,
    input  wire logic [3:0]                S_AXI_WSTRB,
    input  wire logic                      S_AXI_WVALID,
    output logic                           S_AXI_WREADY,
    output logic [1:0]                     S_AXI_BRESP,
    output logic                           S_AXI_BVALID,
    input  wire logic                      S_AXI_BREADY,
    input  wire logic [AXI_AW-1:0]         S_AXI_ARADDR,
    input  wire logic                      S_AXI_ARVALID,
    output logic                           S_AXI_ARREADY,
    output logic [31:0]                    S_AXI_RDATA,
    output logic [1:0]                     S_AXI_RRESP,
    output logic                           S_AXI_RVALID,
    input  wire logic                      S_AXI_RREADY
);
    localparam int NSEG = N_ORANGE + N_GREEN;

    logic             btn_s1_r;
    logic             btn_s2_r;
    logic             btn_db_r;
    logic             btn_prev_r;
    logic [31:0]      deb_cnt_r;
    logic [31:0]      hold_cnt_r;
    logic             long_done_r;
    logic             short_press;
    logic             long_press;
    logic [2:0]       pend_r;
    logic             sel_on_r;
    olm_modes_t       active_r;
    olm_modes_t       active_nxt;
    logic [31:0]      blink_cnt_r;
    logic             blink_r;
    olm_lvl_t         lvl;
    logic             ctrl_txoff_r;
    logic             tx_en_nxt;
    logic             pass_nxt;
    logic [IRQ_W-1:0] irq_st_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic             aw_got_r;
    logic             w_got_r;
    logic [7:0]       awaddr_r;
    logic [31:0]      wdata_r;
    logic             wlane0_r;
    logic             do_wr;
    logic             wr_hit;
    logic [31:0]      rd_mux;
    logic             rd_hit;

    // two-flop synchroniser for the push button
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            btn_s1_r <= 1'b0;
            btn_s2_r <= 1'b0;
        end else begin
            btn_s1_r <= MODE_BTN;
            btn_s2_r <= btn_s1_r;
        end
    end

    // debounce: a new level must hold for the whole debounce window
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            deb_cnt_r <= 32'h0;
            btn_db_r  <= 1'b0;
        end else if (btn_s2_r == btn_db_r) begin
            deb_cnt_r <= 32'h0;
        end else if (deb_cnt_r == 32'(DEB_CYCLES - 1)) begin
            deb_cnt_r <= 32'h0;
            btn_db_r  <= btn_s2_r;
        end else begin
            deb_cnt_r <= deb_cnt_r + 32'h1;
        end
    end

    // a release before the hold time is a short press; reaching it is a long one
    assign short_press = btn_prev_r & ~btn_db_r & ~long_done_r;
    assign long_press  = btn_db_r & ~long_done_r & (hold_cnt_r == 32'(HOLD_CYCLES - 1));

    // hold timer, fires at most once per press
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            btn_prev_r  <= 1'b0;
            hold_cnt_r  <= 32'h0;
            long_done_r <= 1'b0;
        end else begin
            btn_prev_r <= btn_db_r;
            if (!btn_db_r) begin
                if (!btn_prev_r) begin
                    long_done_r <= 1'b0;
                end
                hold_cnt_r <= 32'h0;
            end else if (long_press) begin
                long_done_r <= 1'b1;
            end else if (!long_done_r) begin
                hold_cnt_r <= hold_cnt_r + 32'h1;
            end
        end
    end

    // activation of the pending mode; the main modes exclude each other
    always_comb begin
        active_nxt = active_r;
        if (long_press) begin
            case (pend_r)
                M_NORMAL: begin
                    active_nxt.normal = 1'b1;
                    active_nxt.hand   = 1'b0;
                    active_nxt.align  = 1'b0;
                end
                M_HAND: begin
                    active_nxt.hand    = 1'b1;
                    active_nxt.normal  = 1'b0;
                    active_nxt.align   = 1'b0;
                    active_nxt.pointer = 1'b0;
                    active_nxt.dropout = 1'b0;
                end
                M_ALIGN: begin
                    active_nxt.align   = 1'b1;
                    active_nxt.normal  = 1'b0;
                    active_nxt.hand    = 1'b0;
                    active_nxt.pointer = 1'b0;
                    active_nxt.dropout = 1'b0;
                end
                M_POINTER: begin
                    active_nxt.pointer = ~active_r.pointer;
                    if (!active_r.pointer) begin
                        active_nxt.normal = 1'b1;
                        active_nxt.hand   = 1'b0;
                        active_nxt.align  = 1'b0;
                    end
                end
                M_DROPOUT: begin
                    active_nxt.dropout = ~active_r.dropout;
                    if (!active_r.dropout) begin
                        active_nxt.normal = 1'b1;
                        active_nxt.hand   = 1'b0;
                        active_nxt.align  = 1'b0;
                    end
                end
                M_UPSTREAM: active_nxt.upstream = ~active_r.upstream;
                default:    active_nxt = active_r;
            endcase
        end
    end

    // mode state; reset is the only power-up state, nothing is retained
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            active_r <= MODES_RST;
            pend_r   <= M_NORMAL;
            sel_on_r <= 1'b0;
        end else begin
            active_r <= active_nxt;
            if (short_press) begin
                pend_r   <= (pend_r == M_UPSTREAM) ? M_NORMAL : pend_r + 3'h1;
                sel_on_r <= 1'b1;
            end else if (long_press) begin
                sel_on_r <= 1'b0;
            end
        end
    end

    // flash clock for the pending indicator
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            blink_cnt_r <= 32'h0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_r <= 32'h0;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    // indicators: pending one flashes, the others show their active state
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            MODE_LED <= MODES_RST;
        end else begin
            for (int i = 0; i < NUM_MODES; i++) begin
                if (sel_on_r && pend_r == 3'(i)) begin
                    MODE_LED[i] <= blink_r;
                end else begin
                    MODE_LED[i] <= active_nxt[i];
                end
            end
        end
    end

    // bargraph: orange segments at the bottom, green above them
    for (genvar s = 0; s < NSEG; s++) begin : g_seg
        always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                BARGRAPH[s] <= 1'b0;
            end else begin
                BARGRAPH[s] <= RX_LEVEL >= LVL_W'(SEG_STEP * (s + 1));
            end
        end
    end

    assign lvl.orange_any = BARGRAPH[0];
    assign lvl.green_any  = BARGRAPH[N_ORANGE];

    // transmitter enable, and gating of data by mode and level
    assign tx_en_nxt = ~(EMIT_DIS_IN | ctrl_txoff_r);
    always_comb begin
        if (!TX_ENABLE || active_r.align) begin
            pass_nxt = 1'b0;
        end else if (active_r.hand) begin
            pass_nxt = lvl.green_any;
        end else begin
            pass_nxt = lvl.orange_any;
        end
    end

    // status outputs, all registered
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            TX_ENABLE    <= 1'b0;
            DATA_PASS    <= 1'b0;
            OPT_LINK_LED <= 1'b0;
            LEVEL_WARN_N <= 1'b0;
        end else begin
            TX_ENABLE    <= tx_en_nxt;
            DATA_PASS    <= pass_nxt;
            OPT_LINK_LED <= OPT_LINK_OK & TX_ENABLE;
            LEVEL_WARN_N <= lvl.green_any;
        end
    end

    // ethernet port is fixed at 100 Mbit/s full duplex with auto-crossover
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ETH_SPEED_100   <= 1'b1;
            ETH_FULL_DUPLEX <= 1'b1;
            ETH_AUTO_MDIX   <= 1'b1;
        end else begin
            ETH_SPEED_100   <= 1'b1;
            ETH_FULL_DUPLEX <= 1'b1;
            ETH_AUTO_MDIX   <= 1'b1;
        end
    end

    // events: warning raised, data stopped, optical link lost, mode activated
    assign irq_set[IRQ_WARN] = LEVEL_WARN_N & ~lvl.green_any;
    assign irq_set[IRQ_STOP] = DATA_PASS & ~pass_nxt;
    assign irq_set[IRQ_LINK] = OPT_LINK_LED & ~(OPT_LINK_OK & TX_ENABLE);
    assign irq_set[IRQ_MODE] = long_press;
    assign irq_clr = (do_wr && wlane0_r && awaddr_r == ADDR_IRQS) ? wdata_r[IRQ_W-1:0] : IRQ_RST;

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_st_r <= IRQ_RST;
            IRQ      <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
            IRQ      <= |(irq_st_r & irq_mask_r);
        end
    end

    // write channel: address and data may arrive in either order
    assign do_wr = aw_got_r & w_got_r & ~S_AXI_BVALID;
    always_comb begin
        case (awaddr_r)
            ADDR_CTRL, ADDR_STAT, ADDR_IRQS, ADDR_IRQM, ADDR_MODE, ADDR_LVL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0;
            wlane0_r      <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= {S_AXI_AWADDR[7:2], 2'h0};
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r      <= 1'b1;
                wdata_r      <= S_AXI_WDATA;
                wlane0_r     <= S_AXI_WSTRB[0];
                S_AXI_WREADY <= 1'b0;
            end
            if (do_wr) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVE;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // software registers; only byte lane 0 carries fields
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_txoff_r <= CTRL_RST;
            irq_mask_r   <= IRQ_RST;
        end else if (do_wr && wlane0_r) begin
            if (awaddr_r == ADDR_CTRL) begin
                ctrl_txoff_r <= wdata_r[CTRL_TXOFF];
            end
            if (awaddr_r == ADDR_IRQM) begin
                irq_mask_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    // read decode
    always_comb begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        case ({S_AXI_ARADDR[7:2], 2'h0})
            ADDR_CTRL: rd_mux[CTRL_TXOFF] = ctrl_txoff_r;
            ADDR_STAT: rd_mux[5:0] = {OPT_LINK_LED, lvl.green_any, lvl.orange_any,
                                      DATA_PASS, TX_ENABLE, ~LEVEL_WARN_N};
            ADDR_IRQS: rd_mux[IRQ_W-1:0] = irq_st_r;
            ADDR_IRQM: rd_mux[IRQ_W-1:0] = irq_mask_r;
            ADDR_MODE: begin
                rd_mux[NUM_MODES-1:0]        = active_r;
                rd_mux[MODE_PEND+2:MODE_PEND] = pend_r;
                rd_mux[MODE_SEL]             = sel_on_r;
            end
            ADDR_LVL:  rd_mux[NSEG-1:0] = BARGRAPH;
            default:   rd_hit = 1'b0;
        endcase
    end

    // read channel, one outstanding read
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_mux;
            S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVE;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### test/olm_properties.sv
// checker of olm_top
// assumes it is bound to olm_top and sees only that module's ports
`default_nettype none

module olm_properties
    import olm_pkg::*;
#(
    parameter int N_ORANGE = 2,
    parameter int N_GREEN  = 4
) (
    input wire logic                        CLK,
    input wire logic                        RESET_N,
    input wire logic                        EMIT_DIS_IN,
    input wire logic                        TX_ENABLE,
    input wire logic                        DATA_PASS,
    input wire logic                        OPT_LINK_LED,
    input wire logic                        LEVEL_WARN_N,
    input wire olm_modes_t                  MODE_LED,
    input wire logic [N_ORANGE+N_GREEN-1:0] BARGRAPH,
    input wire logic                        ETH_SPEED_100,
    input wire logic                        ETH_FULL_DUPLEX,
    input wire logic                        ETH_AUTO_MDIX,
    input wire logic                        S_AXI_AWVALID,
    input wire logic                        S_AXI_AWREADY,
    input wire logic                        S_AXI_WVALID,
    input wire logic                        S_AXI_WREADY,
    input wire logic                        S_AXI_BVALID,
    input wire logic                        S_AXI_BREADY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // address and data taken together, as the bench offers them
    sequence wr_take_s;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    // two cycles of steady normal display, so a lagging indicator cannot fool us
    sequence normal_s;
        (MODE_LED == 6'h01) [*2];
    endsequence

    // disable reaches transmitter, then link indicator and data path
    tx_off_a: assert property (EMIT_DIS_IN |=> !TX_ENABLE ##1 (!OPT_LINK_LED && !DATA_PASS))
        else $error("transmitter stays on while disabled");
    link_off_a: assert property (!TX_ENABLE |=> !OPT_LINK_LED)
        else $error("link indicator lit with transmitter off");
    warn_low_a: assert property (!BARGRAPH[N_ORANGE] |=> !LEVEL_WARN_N)
        else $error("no warning without green segment");
    warn_high_a: assert property (BARGRAPH[N_ORANGE] |=> LEVEL_WARN_N)
        else $error("warning with green segment lit");
    stop_pass_a: assert property (!BARGRAPH[0] |=> !DATA_PASS && !LEVEL_WARN_N)
        else $error("data passes or warning off without orange segment");
    orange_pass_a: assert property (normal_s ##0 (BARGRAPH[0] && TX_ENABLE) |=> DATA_PASS)
        else $error("data blocked with orange lit in normal mode");
    eth_fixed_a: assert property (ETH_SPEED_100 && ETH_FULL_DUPLEX && ETH_AUTO_MDIX)
        else $error("ethernet strap dropped");
    wr_resp_a: assert property (wr_take_s |=> (!S_AXI_AWREADY && !S_AXI_WREADY) ##1 S_AXI_BVALID)
        else $error("write response late");
    b_clear_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response held after handshake");
endmodule

bind olm_top olm_properties #(.N_ORANGE(N_ORANGE), .N_GREEN(N_GREEN)) u_olm_properties (
    .CLK, .RESET_N, .EMIT_DIS_IN, .TX_ENABLE, .DATA_PASS, .OPT_LINK_LED, .LEVEL_WARN_N,
    .MODE_LED, .BARGRAPH, .ETH_SPEED_100, .ETH_FULL_DUPLEX, .ETH_AUTO_MDIX, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY);

`default_nettype wire

// ### test/olm_partner.sv
// far side of olm_top: modem level, link status, station disable line, mode button
// assumes its tasks are called from the CLK domain of the bench
`default_nettype none

module olm_partner (
    input  wire logic       CLK,
    output logic [7:0]      rx_level,
    output logic            link_ok,
    output logic            emit_dis,
    output logic            mode_btn
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: good level, link up, transmitter allowed, button released
    initial begin
        rx_level = 8'hc8;
        link_ok  = 1'b1;
        emit_dis = 1'b0;
        mode_btn = 1'b0;
    end

    // level and disable change just after an edge
    task automatic drive(input logic [7:0] lvl, input logic dis);
        @(posedge CLK);
        rx_level <= lvl;
        emit_dis <= dis;
    endtask

    // hold n edges, then idle past sync and debounce
    task automatic press(input int n);
        @(posedge CLK);
        mode_btn <= 1'b1;
        repeat (n) @(posedge CLK);
        mode_btn <= 1'b0;
        repeat (12) @(posedge CLK);
    endtask
endmodule

`default_nettype wire

// ### test/testbench.sv
// self-checking bench of olm_top
// assumes olm_partner as far side and the bound checker
`default_nettype none

module testbench
    import olm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_n;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    wire  [31:0] rdata;
    wire  [1:0]  bresp;
    wire  [1:0]  rresp;
    wire  [7:0]  rx_level;
    wire  [5:0]  bar;
    wire  [2:0]  eth;
    wire olm_modes_t mode_led;
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire         link_ok, emit_dis, mode_btn, warn_n, tx_en, data_pass, link_led;
    int          n_fail;
    int          n_tests;
    logic [7:0]  lv [5] = '{8'hc8, 8'h78, 8'h64, 8'h28, 8'h27};
    logic [7:0]  ex [5] = '{8'hdf, 8'hc7, 8'h83, 8'h81, 8'h00};
    logic [5:0]  act [4] = '{6'h04, 6'h09, 6'h19, 6'h39};

    // short counts keep a long press at tens of cycles
    olm_top #(.HOLD_CYCLES(40), .DEB_CYCLES(4), .BLINK_CYCLES(8)) i_olm_top (
        .CLK(clk), .RESET_N(rst_n), .RX_LEVEL(rx_level), .OPT_LINK_OK(link_ok),
        .EMIT_DIS_IN(emit_dis), .MODE_BTN(mode_btn), .LEVEL_WARN_N(warn_n), .TX_ENABLE(tx_en),
        .DATA_PASS(data_pass), .OPT_LINK_LED(link_led), .MODE_LED(mode_led), .BARGRAPH(bar),
        .ETH_SPEED_100(eth[0]), .ETH_FULL_DUPLEX(eth[1]), .ETH_AUTO_MDIX(eth[2]), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    olm_partner i_olm_partner (.CLK(clk), .rx_level(rx_level), .link_ok(link_ok),
        .emit_dis(emit_dis), .mode_btn(mode_btn));

    // 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bus write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    // bus read: data and response taken at the edge rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a hang ends the run
    initial begin
        cyc(20000);
        n_fail++;
        give_verdict();
    end

    initial begin
        n_fail = 0;
        n_tests = 0;
        rst_n = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        cyc(20);
        rst_n <= 1'b1;
        cyc(3);
        chk("mode_led", 32'h01, 32'(mode_led));
        chk("eth", 32'h7, 32'(eth));
        rd(ADDR_MODE, 32'h01, RESP_OKAY);
        rd(ADDR_CTRL, 32'h0, RESP_OKAY);
        rd(ADDR_IRQM, 32'h0, RESP_OKAY);
        rd(ADDR_LVL, 32'h1f, RESP_OKAY);
        wr(8'h18, 32'h1, RESP_SLVE);
        rd(8'h18, 32'h0, RESP_SLVE);
        // falling level: segments, warning and gating at each step
        for (int i = 0; i < 5; i++) begin
            i_olm_partner.drive(lv[i], 1'b0);
            cyc(3);
            chk("bargraph", 32'(ex[i][5:0]), 32'(bar));
            chk("warn_n", 32'(ex[i][6]), 32'(warn_n));
            chk("data_pass", 32'(ex[i][7]), 32'(data_pass));
        end
        // events latch while masked, line follows the mask, one-to-clear
        wr(ADDR_IRQS, 32'hf, RESP_OKAY);
        i_olm_partner.drive(8'hc8, 1'b0);
        cyc(3);
        i_olm_partner.drive(8'h27, 1'b0);
        cyc(4);
        rd(ADDR_IRQS, 32'h3, RESP_OKAY);
        chk("irq", 32'h0, 32'(irq));
        wr(ADDR_IRQM, 32'h1, RESP_OKAY);
        cyc(2);
        chk("irq", 32'h1, 32'(irq));
        wr(ADDR_IRQS, 32'h1, RESP_OKAY);
        cyc(2);
        chk("irq", 32'h0, 32'(irq));
        // station disable line, then the software disable bit
        i_olm_partner.drive(8'hc8, 1'b1);
        cyc(4);
        chk("tx_enable", 32'h0, 32'(tx_en));
        chk("link_led", 32'h0, 32'(link_led));
        rd(ADDR_IRQS, 32'h6, RESP_OKAY);
        i_olm_partner.drive(8'hc8, 1'b0);
        cyc(4);
        chk("tx_enable", 32'h1, 32'(tx_en));
        chk("link_led", 32'h1, 32'(link_led));
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        cyc(2);
        chk("tx_enable", 32'h0, 32'(tx_en));
        wstrb <= 4'he;
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wstrb <= 4'hf;
        rd(ADDR_CTRL, 32'h1, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        cyc(3);
        rd(ADDR_STAT, 32'h3e, RESP_OKAY);
        // short press selects hand tuning, long press activates it
        wr(ADDR_IRQM, 32'h8, RESP_OKAY);
        i_olm_partner.press(20);
        rd(ADDR_MODE, 32'h1101, RESP_OKAY);
        i_olm_partner.press(60);
        rd(ADDR_MODE, 32'h0102, RESP_OKAY);
        chk("mode_led", 32'h02, 32'(mode_led));
        chk("irq", 32'h1, 32'(irq));
        i_olm_partner.drive(8'h64, 1'b0);
        cyc(4);
        chk("data_pass", 32'h0, 32'(data_pass));
        i_olm_partner.drive(8'h78, 1'b0);
        cyc(4);
        chk("data_pass", 32'h1, 32'(data_pass));
        // every remaining setting selected and activated in order
        for (int k = 2; k < 6; k++) begin
            i_olm_partner.press(20);
            i_olm_partner.press(60);
            rd(ADDR_MODE, 32'(k << 8) | 32'(act[k-2]), RESP_OKAY);
        end
        i_olm_partner.press(20);
        rd(ADDR_MODE, 32'h1039, RESP_OKAY);
        // second reset drops every selection
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        chk("mode_led", 32'h01, 32'(mode_led));
        rd(ADDR_MODE, 32'h01, RESP_OKAY);
        give_verdict();
    end
endmodule

`default_nettype wire
